// File: design/exec_regs.svh
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
// ==================================================
// Opcodes and word layout
`define OPC_CALL_WORKING_REG  16'h0014
`define OPC_MOVE_HI    8'hEB
`define MOVE_SEL_BIT   7
`define WORD2_TAG      4'hF
`define PC_STEP        21'h000002
// ==================================================
// Register map (byte addresses on the 8-bit port)
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_COUNT      8'h08
`define CTRL_EN_BIT    0
`define CTRL_RESET     8'h01
// ==================================================
// Indirect addressing windows, each IND_SPAN bytes long
`define IND_BANK0      12'hFEB
`define IND_BANK1      12'hFE3
`define IND_BANK2      12'hFDB
`define IND_SPAN       12'h005
// ==================================================
// Instruction cycle phases, one mclk each
`define PHASE_Q1       2'h0
`define PHASE_Q2       2'h1
`define PHASE_Q3       2'h2
`define PHASE_Q4       2'h3
`endif

// File: design/exec_pkg.sv
package exec_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CALL1,
      ST_CALL2,
      ST_MOV1,
      ST_MOV2
   } exec_state_t;

   typedef struct packed {
      logic [20:0] pc;
      logic [7:0]  working_reg;
      logic [7:0]  latch_high;
      logic [4:0]  latch_upper;
      logic [11:0] ptr;
   } core_ctx_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        rd;
      logic        wr;
   } dm_req_t;

   typedef struct packed {
      logic        load;
      logic [20:0] value;
   } pc_req_t;

   typedef struct packed {
      logic        push;
      logic [20:0] value;
   } stack_req_t;
endpackage

// File: design/quarter_phase_gen.sv
`timescale 1ns/1ps
`include "exec_regs.svh"
module quarter_phase_gen (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // Phase
   output logic [1:0]      phase,
   output logic            q1,
   output logic            q4
);
   logic [1:0] phase_reg;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         phase_reg <= `PHASE_Q1;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   assign phase = phase_reg;
   assign q1    = (phase_reg == `PHASE_Q1);
   assign q4    = (phase_reg == `PHASE_Q4);
endmodule

// File: design/indirect_addr_check.sv
`timescale 1ns/1ps
`include "exec_regs.svh"
module indirect_addr_check (
   // Address under test
   input  wire logic [11:0] addr,
   // Result
   output logic             hit
);
   localparam logic [11:0] BANK_BASE [3] = '{`IND_BANK0, `IND_BANK1, `IND_BANK2};
   logic [2:0] bank_hit;

   // ==================================================
   // One window compare per indirect bank
   for (genvar b = 0; b < 3; b++) begin : g_bank
      assign bank_hit[b] = (addr >= BANK_BASE[b]) && (addr < 12'(BANK_BASE[b] + `IND_SPAN));
   end

   assign hit = |bank_hit;
endmodule

// File: design/indexed_move_and_working_reg_call_exec.sv
`timescale 1ns/1ps
`include "exec_regs.svh"
module indexed_move_and_working_reg_call_exec
   import exec_pkg::*;
(
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   // Register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [7:0]                 reg_rdata,
   // Fetch path
   input  wire logic [15:0]           instr_word,
   input  wire logic                  instr_valid,
   output logic [1:0]                 cycle_phase,
   output logic                       exec_busy,
   // Core state
   input  exec_pkg::core_ctx_t        ctx,
   // Data memory
   input  wire logic [7:0]            dm_rdata,
   output exec_pkg::dm_req_t          dm,
   // Program counter and return stack
   output exec_pkg::pc_req_t          pc_req,
   output exec_pkg::stack_req_t       stack_req
);
   import exec_pkg::*;

   exec_state_t state_reg;
   exec_state_t state_next;
   logic [1:0]  phase;
   logic        q1;
   logic        q4;
   logic [7:0]  ctrl_reg;
   logic [7:0]  count_reg;
   logic [1:0]  last_op_reg;
   logic [7:0]  rdata_reg;
   logic [6:0]  src_off_reg;
   logic        move_ss_reg;
   logic [15:0] word2_reg;
   logic        src_ind_reg;
   logic [11:0] dm_addr_reg;
   logic [7:0]  dm_wdata_reg;
   logic [20:0] pc_val_reg;
   logic [20:0] stack_val_reg;

   // ==================================================
   // Phase and address check
   quarter_phase_gen u_phase (
      .mclk  (mclk),
      .rstn  (rstn),
      .phase (phase),
      .q1    (q1),
      .q4    (q4)
   );

   logic addr_indirect;
   indirect_addr_check u_ind (
      .addr (dm_addr_reg),
      .hit  (addr_indirect)
   );

   // ==================================================
   // Decode
   wire         ctrl_en   = ctrl_reg[`CTRL_EN_BIT];
   wire         is_call   = (instr_word == `OPC_CALL_WORKING_REG);
   wire         is_move   = (instr_word[15:8] == `OPC_MOVE_HI);
   wire         start     = q1 && (state_reg == ST_IDLE) && instr_valid && ctrl_en;
   wire         in_call1  = (state_reg == ST_CALL1);
   wire         in_mov1   = (state_reg == ST_MOV1);
   wire         in_mov2   = (state_reg == ST_MOV2);
   wire         word2_ok  = (word2_reg[15:12] == `WORD2_TAG);
   // Twelve-bit sums wrap, so any pointer and offset land inside the space
   wire [11:0]  src_addr  = 12'(ctx.ptr + {5'h00, src_off_reg});
   wire [11:0]  rel_dest  = 12'(ctx.ptr + {5'h00, word2_reg[6:0]});
   wire [11:0]  dst_addr  = move_ss_reg ? rel_dest : word2_reg[11:0];
   wire         dst_block = move_ss_reg && addr_indirect;
   wire         fin       = q4 && ((state_reg == ST_CALL2) || in_mov2);

   // ==================================================
   // Sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (start && is_call) begin
               state_next = ST_CALL1;
            end else if (start && is_move) begin
               state_next = ST_MOV1;
            end
         end
         ST_CALL1: begin
            if (q4) begin
               state_next = ST_CALL2;
            end
         end
         ST_CALL2: begin
            if (q4) begin
               state_next = ST_IDLE;
            end
         end
         ST_MOV1: begin
            if (q4) begin
               state_next = ST_MOV2;
            end
         end
         ST_MOV2: begin
            if (q4) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==================================================
   // Instruction operands
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         src_off_reg   <= 7'h00;
         move_ss_reg   <= 1'b0;
         word2_reg     <= 16'h0000;
         stack_val_reg <= 21'h000000;
      end else if (start) begin
         src_off_reg   <= instr_word[6:0];
         move_ss_reg   <= instr_word[`MOVE_SEL_BIT];
         stack_val_reg <= 21'(ctx.pc + `PC_STEP);
      end else if (in_mov2 && q1) begin
         word2_reg     <= instr_word;
      end
   end

   // ==================================================
   // Counter target, read at the second phase as the working register read
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pc_val_reg <= 21'h000000;
      end else if (in_call1 && (phase == `PHASE_Q2)) begin
         pc_val_reg <= {ctx.latch_upper, ctx.latch_high, ctx.working_reg};
      end
   end

   // ==================================================
   // Data memory address and data
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         dm_addr_reg <= 12'h000;
      end else if (in_mov1 && (phase == `PHASE_Q2)) begin
         dm_addr_reg <= src_addr;
      end else if (in_mov2 && (phase == `PHASE_Q2)) begin
         dm_addr_reg <= dst_addr;
      end
   end

   // Read data arrive one mclk after the strobe, which is the first phase of cycle two
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         src_ind_reg  <= 1'b0;
         dm_wdata_reg <= 8'h00;
      end else if (in_mov1 && q4) begin
         src_ind_reg  <= addr_indirect;
      end else if (in_mov2 && q1) begin
         dm_wdata_reg <= src_ind_reg ? 8'h00 : dm_rdata;
      end
   end

   // ==================================================
   // Strobes; no flag, working or bank register port exists on this block
   assign dm.addr         = dm_addr_reg;
   assign dm.wdata        = dm_wdata_reg;
   assign dm.rd           = in_mov1 && q4;
   // A malformed second word is dropped rather than written
   assign dm.wr           = in_mov2 && q4 && word2_ok && !dst_block;
   assign pc_req.load     = in_call1 && q4;
   assign pc_req.value    = pc_val_reg;
   assign stack_req.push  = in_call1 && (phase == `PHASE_Q3);
   assign stack_req.value = stack_val_reg;
   assign cycle_phase     = phase;
   assign exec_busy       = (state_reg != ST_IDLE);

   // ==================================================
   // Registers
   wire       sel_ctrl   = (reg_addr == `REG_CTRL);
   wire       sel_status = (reg_addr == `REG_STATUS);
   wire       sel_count  = (reg_addr == `REG_COUNT);
   wire [7:0] status_val = {5'h00, last_op_reg, exec_busy};
   wire [7:0] read_mux   = sel_ctrl   ? ctrl_reg   :
                           sel_status ? status_val :
                           sel_count  ? count_reg  : 8'h00;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (reg_wr && sel_ctrl) begin
         ctrl_reg <= {7'h00, reg_wdata[`CTRL_EN_BIT]};
      end
   end

   // Count wraps; software takes differences
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         count_reg   <= 8'h00;
         last_op_reg <= 2'h0;
      end else if (fin) begin
         count_reg   <= count_reg + 8'h01;
         last_op_reg <= in_mov2 ? {1'b1, move_ss_reg} : 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         rdata_reg <= read_mux;
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign reg_rdata = rdata_reg;

   // ==================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_push_value;
      start && is_call |-> ##2 (stack_req.push && stack_req.value == 21'($past(ctx.pc, 2) + `PC_STEP));
   endproperty
   a_push_value: assert property (p_push_value) else $error("push value wrong");

   property p_pc_low;
      start && is_call |-> ##3 (pc_req.load && pc_req.value[7:0] == $past(ctx.working_reg, 2));
   endproperty
   a_pc_low: assert property (p_pc_low) else $error("pc low not from working reg");

   property p_pc_upper;
      pc_req.load |-> pc_req.value[20:8] == {$past(ctx.latch_upper, 2), $past(ctx.latch_high, 2)};
   endproperty
   a_pc_upper: assert property (p_pc_upper) else $error("pc upper not from latches");

   property p_call_len;
      start && is_call |-> ##1 exec_busy [*7] ##1 !exec_busy;
   endproperty
   a_call_len: assert property (p_call_len) else $error("call length wrong");

   property p_call_no_mem;
      in_call1 || (state_reg == ST_CALL2) |-> !dm.rd && !dm.wr;
   endproperty
   a_call_no_mem: assert property (p_call_no_mem) else $error("call touched memory");

   property p_src_addr;
      start && is_move |-> ##3 (dm.rd && dm.addr == 12'($past(ctx.ptr, 2) + {5'h00, $past(instr_word[6:0], 3)}));
   endproperty
   a_src_addr: assert property (p_src_addr) else $error("source address wrong");

   property p_abs_dest;
      dm.wr && !move_ss_reg |-> dm.addr == $past(instr_word[11:0], 3);
   endproperty
   a_abs_dest: assert property (p_abs_dest) else $error("absolute dest wrong");

   property p_rel_dest;
      dm.wr && move_ss_reg |-> dm.addr == 12'($past(ctx.ptr, 2) + {5'h00, $past(instr_word[6:0], 3)});
   endproperty
   a_rel_dest: assert property (p_rel_dest) else $error("indexed dest wrong");

   property p_src_zero;
      dm.rd && addr_indirect |-> ##4 (dm.wdata == 8'h00);
   endproperty
   a_src_zero: assert property (p_src_zero) else $error("indirect source not zero");

   property p_ind_nop;
      in_mov2 && move_ss_reg && addr_indirect |-> !dm.wr;
   endproperty
   a_ind_nop: assert property (p_ind_nop) else $error("write to indirect dest");

   property p_write_phase;
      dm.wr |-> (phase == `PHASE_Q4) && $past(dm.rd, 4);
   endproperty
   a_write_phase: assert property (p_write_phase) else $error("write not four after read");

   c_call:   cover property (start && is_call ##3 pc_req.load);
   c_absmov: cover property (dm.rd ##4 (dm.wr && !move_ss_reg));
   c_ssnop:  cover property (in_mov2 && q4 && move_ss_reg && addr_indirect);
endmodule

// File: verif/core_mem_model.sv
`timescale 1ns/1ps
module core_mem_model
   import exec_pkg::*;
(
   // Clock
   input  wire logic         mclk,
   // Data memory request
   input  exec_pkg::dm_req_t dm,
   output logic [7:0]        dm_rdata
);
   import exec_pkg::*;

   logic [7:0] mem [0:4095];

   initial begin
      dm_rdata = 8'h00;
   end

   // ==================================================
   // Storage
   // Read data stand for one cycle only; otherwise they toggle so a late sample is caught
   always @(posedge mclk) begin
      if (dm.rd) begin
         dm_rdata <= mem[dm.addr];
      end else begin
         dm_rdata <= ~dm_rdata;
      end
      if (dm.wr) begin
         mem[dm.addr] <= dm.wdata;
      end
   end
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
`include "exec_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module tb;
   import exec_pkg::*;

   logic             mclk;
   logic             rstn;
   logic [7:0]       reg_addr;
   logic [7:0]       reg_wdata;
   logic             reg_wr;
   logic             reg_rd;
   logic [7:0]       reg_rdata;
   logic [15:0]      instr_word;
   logic             instr_valid;
   logic [1:0]       cycle_phase;
   logic             exec_busy;
   core_ctx_t        ctx;
   logic [7:0]       dm_rdata;
   dm_req_t          dm;
   pc_req_t          pc_req;
   stack_req_t       stack_req;
   int               n_mismatch;
   int               n_checks;
   int               cyc;

   indexed_move_and_working_reg_call_exec i_dut (
      .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_word(instr_word), .instr_valid(instr_valid),
      .cycle_phase(cycle_phase), .exec_busy(exec_busy), .ctx(ctx), .dm_rdata(dm_rdata), .dm(dm),
      .pc_req(pc_req), .stack_req(stack_req));

   core_mem_model i_mem (.mclk(mclk), .dm(dm), .dm_rdata(dm_rdata));

   // ==================================================
   // Clock and watchdog
   always #12.5 mclk = ~mclk;

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ==================================================
   // Register port
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK(nm, e, reg_rdata)
   endtask

   // ==================================================
   // Instruction issue, aligned so the first word stands through phase 0
   task automatic issue(input logic [15:0] w);
      // Look at the phase only once it has settled after the edge
      #1;
      for (int k = 0; k < 8 && cycle_phase !== 2'h3; k++) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      instr_word <= w;
      instr_valid <= 1'b1;
   endtask

   task automatic run(input logic [15:0] w1, input logic [15:0] w2, input logic [20:0] pexp,
                      input logic [11:0] src, input logic [11:0] dst, input logic [7:0] d,
                      input bit wr_exp, input bit is_call);
      logic [20:0] push_exp;
      // Taken after issue so that a context change made at the same edge has settled
      issue(w1);
      push_exp = ctx.pc + 21'h000002;
      for (int i = 1; i <= 8; i++) begin
         @(posedge mclk);
         instr_valid <= 1'b0;
         if (i == 4) begin
            instr_word <= w2;
         end
         #1;
         `CHK("busy", (i < 8), exec_busy)
         `CHK("phase", 2'(i % 4), cycle_phase)
         `CHK("push", (is_call && i == 2), stack_req.push)
         `CHK("load", (is_call && i == 3), pc_req.load)
         `CHK("rd", (!is_call && i == 3), dm.rd)
         `CHK("wr", (wr_exp && i == 7), dm.wr)
         if (is_call && i == 2) `CHK("push_val", push_exp, stack_req.value)
         if (is_call && i == 3) `CHK("pc_val", pexp, pc_req.value)
         if (!is_call && i == 3) `CHK("src", src, dm.addr)
         if (wr_exp && i == 7) `CHK("dst", dst, dm.addr)
         if (wr_exp && i == 7) `CHK("wdata", d, dm.wdata)
      end
      if (wr_exp) `CHK("mem", d, i_mem.mem[dst])
   endtask

   task automatic mv(input logic [11:0] p, input logic [15:0] w1, input logic [15:0] w2,
                     input logic [11:0] src, input logic [11:0] dst, input logic [7:0] pre,
                     input logic [7:0] d, input bit wr_exp);
      @(posedge mclk);
      ctx.ptr <= p;
      i_mem.mem[src] = pre;
      run(w1, w2, 21'h000000, src, dst, d, wr_exp, 1'b0);
   endtask

   // ==================================================
   // Main sequence
   initial begin
      mclk = 1'b0;
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      instr_word = 16'h0000;
      instr_valid = 1'b0;
      ctx = '0;
      n_mismatch = 0;
      n_checks = 0;
      cyc = 0;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      reg_read(`REG_CTRL, 8'h01, "ctrl_rst");
      reg_read(`REG_STATUS, 8'h00, "status_rst");
      reg_read(`REG_COUNT, 8'h00, "count_rst");
      reg_read(8'h0C, 8'h00, "unmapped");
      reg_write(`REG_STATUS, 8'hFF);
      reg_read(`REG_STATUS, 8'h00, "status_ro");
      @(posedge mclk);
      ctx <= '{pc: 21'h001234, working_reg: 8'h06, latch_high: 8'h10, latch_upper: 5'h00, ptr: 12'h080};
      run(16'h0014, 16'h0000, 21'h001006, 12'h000, 12'h000, 8'h00, 1'b0, 1'b1);
      @(posedge mclk);
      ctx <= '{pc: 21'h1FFFF0, working_reg: 8'h3C, latch_high: 8'hA5, latch_upper: 5'h1F, ptr: 12'h080};
      run(16'h0014, 16'h0000, 21'h1FA53C, 12'h000, 12'h000, 8'h00, 1'b0, 1'b1);
      reg_read(`REG_COUNT, 8'h02, "count");
      reg_read(`REG_STATUS, 8'h02, "status_call");
      // Destinations avoid counter low and stack top bytes
      mv(12'h080, 16'hEB05, 16'hF123, 12'h085, 12'h123, 8'h33, 8'h33, 1'b1);
      mv(12'hF80, 16'hEB7F, 16'hF000, 12'hFFF, 12'h000, 8'h5A, 8'h5A, 1'b1);
      mv(12'hFE0, 16'hEB0B, 16'hF200, 12'hFEB, 12'h200, 8'h77, 8'h00, 1'b1);
      reg_read(`REG_STATUS, 8'h04, "status_abs");
      mv(12'h080, 16'hEB85, 16'hFF86, 12'h085, 12'h086, 8'h33, 8'h33, 1'b1);
      mv(12'hFE0, 16'hEB80, 16'hF00B, 12'hFE0, 12'hFEB, 8'h44, 8'h00, 1'b0);
      reg_read(`REG_STATUS, 8'h06, "status_idx");
      reg_read(`REG_COUNT, 8'h07, "count_all");
      reg_write(`REG_CTRL, 8'h00);
      reg_read(`REG_CTRL, 8'h00, "ctrl_off");
      issue(16'h0014);
      repeat (8) begin
         @(posedge mclk);
         instr_valid <= 1'b0;
         #1;
         `CHK("off_busy", 1'b0, exec_busy)
         `CHK("off_push", 1'b0, stack_req.push)
      end
      reg_write(`REG_CTRL, 8'h01);
      reg_read(`REG_CTRL, 8'h01, "ctrl_on");
      summarize();
   end
endmodule
